// ===== core/acqc_pkg.sv
// constants, register map and state encoding for the acquisition control block
package acqc_pkg;
    localparam logic [7:0]  ADDR_ACQ_MODE      = 8'hd2;
    localparam logic [7:0]  ADDR_CONV_STATUS   = 8'hd3;
    localparam logic [7:0]  ADDR_SHUNT_CFG     = 8'hd4;

    localparam logic [7:0]  ACQ_MODE_RST       = 8'h0a;
    localparam logic [7:0]  CONV_STATUS_RST    = 8'h00;
    localparam logic [15:0] SHUNT_CFG_RST      = 16'h0387;
    localparam logic [7:0]  ACQ_MODE_MASK      = 8'h7f;
    localparam logic [15:0] SHUNT_CFG_MASK     = 16'h3fff;

    // acquisition mode fields
    localparam int          MODE_PD_BIT        = 6;
    localparam int          MODE_IDLE_BIT      = 5;
    localparam int          MODE_POST_PD_BIT   = 4;
    localparam int          MODE_CONT_BIT      = 3;
    localparam int          MODE_OP_LSB        = 0;
    localparam int          MODE_OP_W          = 3;

    // conversion status fields
    localparam int          STAT_RDY_BIT       = 1;
    localparam int          STAT_OVF_BIT       = 0;

    // shunt channel config fields
    localparam int          CFG_AUX_AVG_LSB    = 10;
    localparam int          CFG_AUX_TIME_LSB   = 7;
    localparam int          CFG_PRI_AVG_LSB    = 3;
    localparam int          CFG_PRI_TIME_LSB   = 0;
    localparam int          CFG_AVG_W          = 4;
    localparam int          CFG_TIME_W         = 3;

    // measured inputs, in walk order
    localparam int          NUM_CHAN           = 5;
    localparam logic [2:0]  CH_PRI_SHUNT       = 3'h0;
    localparam logic [2:0]  CH_PRI_BUS         = 3'h1;
    localparam logic [2:0]  CH_AUX_SHUNT       = 3'h2;
    localparam logic [2:0]  CH_AUX_BUS         = 3'h3;
    localparam logic [2:0]  CH_TEMP            = 3'h4;

    // shortest conversion time and the clock
    localparam int          CONV_TIME_MIN_NS   = 64000;
    localparam int          CLK_PERIOD_NS      = 10;
    localparam int          CONV_BASE_CYCLES_DFLT = (CONV_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          AVG_LOG_MAX        = 12;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONV  = 3'b010,
        ST_STORE = 3'b100
    } acqc_state_e;
endpackage

// ===== core/acqc_top.sv
// acquisition mode, conversion status and shunt configuration with the measurement sequencer
`timescale 1ns/1ps
module acqc_top #(
    parameter int unsigned CONV_BASE_CYCLES = acqc_pkg::CONV_BASE_CYCLES_DFLT,
    parameter int unsigned SAMPLE_W         = 16
) (
    input  wire logic                clock,
    input  wire logic                srst,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [15:0]         reg_wdata,
    output logic      [15:0]         reg_rdata,
    output logic                     reg_rd_valid,
    output logic                     converter_power_down,
    output logic                     converter_idle,
    output logic                     conv_start,
    output logic      [2:0]          conv_channel,
    input  wire logic [SAMPLE_W-1:0] adc_sample,
    input  wire logic                math_range_error,
    output logic                     result_valid,
    output logic      [2:0]          result_channel,
    output logic      [SAMPLE_W-1:0] result_data,
    output logic      [SAMPLE_W-1:0] shunt_result_primary,
    output logic      [SAMPLE_W-1:0] shunt_result_aux
);
    import acqc_pkg::*;

    localparam int CNT_W = $clog2(CONV_BASE_CYCLES * 32 + 1);
    localparam int ACC_W = SAMPLE_W + AVG_LOG_MAX + 1;

    // the counter and accumulator widths are derived from these; other values would overflow them
    if (CONV_BASE_CYCLES < 1 || CONV_BASE_CYCLES > 65536 || SAMPLE_W < 2 || SAMPLE_W > 32) begin : g_bad_param
        $error("acqc_top: unsupported parameter value");
    end

    logic [7:0]              mode;
    logic [15:0]             shunt_cfg;
    logic                    ready_flag;
    logic                    ovf_flag;
    logic                    post_hold;
    logic                    trig_pending;
    acqc_state_e             st;
    logic [2:0]              chan;
    logic [CNT_W-1:0]        conv_cnt;
    logic [AVG_LOG_MAX:0]    samp_cnt;
    logic signed [ACC_W-1:0] acc;

    // register access decode; the serial engine hands decoded word accesses in here
    wire mode_wr    = reg_wr && (reg_addr == ADDR_ACQ_MODE);
    wire cfg_wr     = reg_wr && (reg_addr == ADDR_SHUNT_CFG);
    wire continuous = mode[MODE_CONT_BIT];

    // inputs selected by the operating mode field, one bit per walk position
    wire [2:0] op_mode = mode[MODE_OP_LSB +: MODE_OP_W];
    logic [NUM_CHAN-1:0] ch_mask;
    always_comb begin
        case (op_mode)
            3'h0:    ch_mask = 5'h01;
            3'h1:    ch_mask = 5'h02;
            3'h2:    ch_mask = 5'h03;
            3'h3:    ch_mask = 5'h04;
            3'h4:    ch_mask = 5'h08;
            3'h5:    ch_mask = 5'h0c;
            3'h6:    ch_mask = 5'h10;
            default: ch_mask = 5'h1f;
        endcase
    end

    // lowest selected channel at or above a walk position
    function automatic logic [3:0] find_from(input logic [NUM_CHAN-1:0] m, input int from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (i >= from && m[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    wire [3:0] first_ch = find_from(ch_mask, 0);
    wire [3:0] next_ch  = find_from(ch_mask, int'(chan) + 1);

    // the primary fields serve the primary inputs, the auxiliary fields the rest
    wire       use_pri  = (chan == CH_PRI_SHUNT) || (chan == CH_PRI_BUS);
    wire       is_shunt = (chan == CH_PRI_SHUNT) || (chan == CH_AUX_SHUNT);
    wire [2:0] t_code   = use_pri ? shunt_cfg[CFG_PRI_TIME_LSB +: CFG_TIME_W] : shunt_cfg[CFG_AUX_TIME_LSB +: CFG_TIME_W];
    wire [3:0] a_code   = use_pri ? shunt_cfg[CFG_PRI_AVG_LSB +: CFG_AVG_W] : shunt_cfg[CFG_AUX_AVG_LSB +: CFG_AVG_W];

    // codes 1xx ignore their lowest bit
    // limitation: each sample also spends its start cycle, one clock over the coded count
    wire [2:0] t_shift  = t_code[2] ? (t_code[1] ? 3'h5 : 3'h4) : {1'b0, t_code[1:0]};
    wire [CNT_W-1:0] conv_cycles = CNT_W'(CONV_BASE_CYCLES) << t_shift;

    // averaging only applies to the shunt inputs; the bus inputs take one sample here
    wire [3:0] avg_log  = !is_shunt ? 4'h0 : ((a_code[3:2] == 2'b11) ? 4'(AVG_LOG_MAX) : a_code);
    wire [AVG_LOG_MAX:0] last_samp = (AVG_LOG_MAX + 1)'((1 << avg_log) - 1);

    wire signed [ACC_W-1:0] sum_now = acc + ACC_W'($signed(adc_sample));
    wire signed [ACC_W-1:0] avg_now = sum_now >>> avg_log;

    wire conv_last   = (st == ST_CONV) && (conv_cnt == '0);
    wire samp_last   = conv_last && (samp_cnt == last_samp);
    wire cycle_end   = (st == ST_STORE) && !next_ch[3] && !mode_wr;
    wire run_allowed = !mode[MODE_PD_BIT] && !mode[MODE_IDLE_BIT] && !post_hold;
    wire start_cycle = (st == ST_IDLE) && run_allowed && (continuous || trig_pending) && !mode_wr;

    // register file
    always_ff @(posedge clock) begin
        if (srst) begin
            mode      <= ACQ_MODE_RST;
            shunt_cfg <= SHUNT_CFG_RST;
        end else begin
            if (mode_wr) begin
                mode <= reg_wdata[7:0] & ACQ_MODE_MASK;
            end
            if (cfg_wr) begin
                shunt_cfg <= reg_wdata & SHUNT_CFG_MASK;
            end
        end
    end

    // ready is only defined in triggered operation; a same-cycle write beats a finishing cycle and clears ready
    always_ff @(posedge clock) begin
        if (srst) begin
            ready_flag <= CONV_STATUS_RST[STAT_RDY_BIT];
            ovf_flag   <= CONV_STATUS_RST[STAT_OVF_BIT];
        end else begin
            if (cycle_end && !continuous) begin
                ready_flag <= 1'b1;
            end else if (mode_wr) begin
                ready_flag <= 1'b0;
            end
            if (cycle_end) begin
                ovf_flag <= math_range_error;
            end
        end
    end

    // post-trigger hold keeps the converter parked until the next mode write
    always_ff @(posedge clock) begin
        if (srst) begin
            post_hold    <= 1'b0;
            trig_pending <= 1'b0;
        end else begin
            if (mode_wr) begin
                post_hold    <= 1'b0;
                trig_pending <= 1'b1;
            end else begin
                if (cycle_end && !continuous) begin
                    post_hold <= 1'b1;
                end
                if (start_cycle) begin
                    trig_pending <= 1'b0;
                end
            end
        end
    end

    // sequencer; a mode write abandons any cycle in flight so the new setting starts clean
    always_ff @(posedge clock) begin
        if (srst) begin
            st       <= ST_IDLE;
            chan     <= CH_PRI_SHUNT;
            conv_cnt <= '0;
            samp_cnt <= '0;
            acc      <= '0;
        end else if (mode_wr) begin
            st <= ST_IDLE;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (start_cycle && first_ch[3]) begin
                        st       <= ST_CONV;
                        chan     <= first_ch[2:0];
                        samp_cnt <= '0;
                        acc      <= '0;
                    end
                end
                ST_CONV: begin
                    if (conv_cnt == '0 && !conv_start) begin
                        if (samp_last) begin
                            st <= ST_STORE;
                        end else begin
                            samp_cnt <= samp_cnt + 1'b1;
                            acc      <= sum_now;
                        end
                    end else if (conv_start) begin
                        conv_cnt <= conv_cycles - 1'b1;
                    end else begin
                        conv_cnt <= conv_cnt - 1'b1;
                    end
                end
                ST_STORE: begin
                    samp_cnt <= '0;
                    acc      <= '0;
                    if (next_ch[3]) begin
                        st   <= ST_CONV;
                        chan <= next_ch[2:0];
                    end else begin
                        st <= ST_IDLE;
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // one sample starts on entering a channel and again after each finished sample except the channel's last
    logic conv_armed;
    always_ff @(posedge clock) begin
        if (srst) begin
            conv_armed <= 1'b0;
        end else begin
            conv_armed <= (st == ST_IDLE && start_cycle && first_ch[3] && !mode_wr)
                       || (st == ST_STORE && next_ch[3] && !mode_wr)
                       || (conv_last && !conv_start && !samp_last && !mode_wr);
        end
    end
    assign conv_start = conv_armed && (st == ST_CONV);

    // results hold the average of the samples just taken
    logic signed [SAMPLE_W-1:0] avg_hold;
    always_ff @(posedge clock) begin
        if (srst) begin
            avg_hold             <= '0;
            result_valid         <= 1'b0;
            result_channel       <= CH_PRI_SHUNT;
            result_data          <= '0;
            shunt_result_primary <= '0;
            shunt_result_aux     <= '0;
        end else begin
            result_valid <= 1'b0;
            if (samp_last && !conv_start && !mode_wr) begin
                avg_hold <= avg_now[SAMPLE_W-1:0];
            end
            if (st == ST_STORE && !mode_wr) begin
                result_valid   <= 1'b1;
                result_channel <= chan;
                result_data    <= avg_hold;
                if (chan == CH_PRI_SHUNT) begin
                    shunt_result_primary <= avg_hold;
                end
                if (chan == CH_AUX_SHUNT) begin
                    shunt_result_aux <= avg_hold;
                end
            end
        end
    end

    // converter power and idle controls follow the mode bits and the post-trigger hold
    assign converter_power_down = mode[MODE_PD_BIT] || (post_hold && mode[MODE_POST_PD_BIT]);
    assign converter_idle       = !converter_power_down && (st == ST_IDLE);
    assign conv_channel         = chan;

    // read answers one cycle after the strobe; unmapped addresses read zero
    wire [15:0] rd_mux = (reg_addr == ADDR_ACQ_MODE)    ? {8'h00, mode} :
                         (reg_addr == ADDR_CONV_STATUS) ? {14'h0000, ready_flag, ovf_flag} :
                         (reg_addr == ADDR_SHUNT_CFG)   ? shunt_cfg : 16'h0000;
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata    <= 16'h0000;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_mode_reset_value: assert property (@(posedge clock) disable iff (1'b0) srst |=> mode == ACQ_MODE_RST)
        else $error("mode register not at reset value");
    a_power_up_run: assert property ($past(srst) && !srst |=> st == ST_CONV)
        else $error("converter did not start after power-up");
    a_power_down_out: assert property (mode[MODE_PD_BIT] |-> converter_power_down && st == ST_IDLE)
        else $error("power-down bit did not stop converter");
    a_idle_no_acq: assert property (st != ST_IDLE |-> !mode[MODE_IDLE_BIT] && !post_hold)
        else $error("acquisition while idle selected");
    a_post_trig_state: assert property (cycle_end && !continuous |=> post_hold && st == ST_IDLE
        && converter_power_down == mode[MODE_POST_PD_BIT])
        else $error("wrong state after triggered acquisition");
    a_cont_repeats: assert property (cycle_end && continuous && run_allowed ##1 !mode_wr |=> st == ST_CONV)
        else $error("continuous operation did not repeat");
    a_trig_write_starts: assert property (mode_wr && !reg_wdata[MODE_CONT_BIT] && !reg_wdata[MODE_PD_BIT]
        && !reg_wdata[MODE_IDLE_BIT] ##1 !mode_wr |=> st == ST_CONV)
        else $error("mode write did not start triggered cycle");
    a_chan_selected: assert property (st == ST_CONV |-> ch_mask[chan])
        else $error("unselected input measured");
    a_ready_rises: assert property (cycle_end && !continuous |=> ready_flag && $rose(result_valid))
        else $error("ready not set with results");
    a_write_clears_ready: assert property (mode_wr && !cycle_end |=> !ready_flag)
        else $error("mode write did not clear ready");
    a_ovf_update: assert property (cycle_end |=> ovf_flag == $past(math_range_error))
        else $error("overflow not refreshed at cycle end");
    a_conv_time_load: assert property (conv_start && !mode_wr |=> conv_cnt == $past(conv_cycles) - 1'b1)
        else $error("conversion time not loaded");
    a_avg_count: assert property ($rose(st == ST_STORE) |-> $past(samp_cnt) == $past(last_samp))
        else $error("wrong number of averaged samples");
    a_avg_bus_single: assert property (st == ST_CONV && !is_shunt |-> samp_cnt == '0)
        else $error("bus input averaged");
    a_rd_answer: assert property (reg_rd |=> reg_rd_valid && reg_rdata == $past(rd_mux))
        else $error("register read not answered");
    a_result_store: assert property (result_valid |-> $past(st == ST_STORE) && result_channel == $past(chan))
        else $error("result not from store step");
    a_idle_state_out: assert property (mode[MODE_IDLE_BIT] && !converter_power_down |-> converter_idle)
        else $error("idle state not shown");
    a_single_result: assert property (post_hold |-> st == ST_IDLE && !conv_start)
        else $error("triggered operation did not stop");
    a_pd_no_start: assert property (converter_power_down |-> !conv_start && st == ST_IDLE)
        else $error("sample started while powered down");
    a_ovf_hold: assert property (!cycle_end |=> $stable(ovf_flag))
        else $error("overflow changed outside cycle end");

    c_trig_done:  cover property (cycle_end && !continuous && mode[MODE_POST_PD_BIT]);
    c_cont_cycle: cover property (cycle_end && continuous ##[1:300] cycle_end);
    c_all_inputs: cover property (st == ST_CONV && op_mode == 3'h7 && chan == CH_TEMP);
    c_max_avg:    cover property (st == ST_CONV && avg_log == 4'(AVG_LOG_MAX));
    c_write_abort: cover property (mode_wr && st == ST_CONV);
endmodule

// ===== tb/acqc_adc_model.sv
// converter front end model: per-channel sample value and range error input
`timescale 1ns/1ps
module acqc_adc_model (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        conv_start,
    input  wire logic [2:0]  conv_channel,
    input  wire logic        range_err_req,
    output logic      [15:0] adc_sample,
    output logic             math_range_error
);
    logic tog;

    // alternating +4 offset: any even-count average lands on base + 2, a lone sample does not
    always_ff @(posedge clock) begin
        if (srst) begin
            tog <= 1'b0;
        end else if (conv_start) begin
            tog <= ~tog;
        end
    end

    assign adc_sample       = {1'b0, conv_channel, 12'h100} + (tog ? 16'h0004 : 16'h0000);
    assign math_range_error = range_err_req;
endmodule

// ===== tb/adc_acquisition_control_tb.sv
// self-checking bench for the acquisition control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module adc_acquisition_control_tb;
    import acqc_pkg::*;
    typedef struct packed { logic [7:0] a; logic w; logic [15:0] d; logic [15:0] e; } acqc_row_s;
    localparam acqc_row_s ROWS [8] = '{
        '{8'hd2, 1'b0, 16'h0000, 16'h000a}, '{8'hd4, 1'b0, 16'h0000, 16'h0387},
        '{8'hd5, 1'b0, 16'h0000, 16'h0000}, '{8'hd4, 1'b1, 16'hffff, 16'h3fff},
        '{8'hd4, 1'b1, 16'h2a5a, 16'h2a5a}, '{8'hd2, 1'b1, 16'h00ff, 16'h007f},
        '{8'hc0, 1'b1, 16'hffff, 16'h0000}, '{8'hd2, 1'b1, 16'h000a, 16'h000a}};
    localparam logic [4:0] MASKS [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h1f};
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        ovf_req = 1'b0;
    logic [15:0] reg_rdata, adc_sample, result_data, shunt_result_primary, shunt_result_aux, rd;
    logic        reg_rd_valid, converter_power_down, converter_idle, conv_start, math_range_error, result_valid;
    logic [2:0]  conv_channel, result_channel;
    logic [4:0]  mask;
    int          fails = 0;
    int          check_count = 0;
    int          cyc, t0, n, sh;

    acqc_top #(.CONV_BASE_CYCLES(4), .SAMPLE_W(16)) DUT (.clock(clock), .srst(srst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .converter_power_down(converter_power_down),
        .converter_idle(converter_idle), .conv_start(conv_start), .conv_channel(conv_channel),
        .adc_sample(adc_sample), .math_range_error(math_range_error), .result_valid(result_valid),
        .result_channel(result_channel), .result_data(result_data),
        .shunt_result_primary(shunt_result_primary), .shunt_result_aux(shunt_result_aux));
    acqc_adc_model far_end (.clock(clock), .srst(srst), .conv_start(conv_start), .conv_channel(conv_channel),
        .range_err_req(ovf_req), .adc_sample(adc_sample), .math_range_error(math_range_error));

    initial begin
        forever #5 clock = ~clock;
    end

    task automatic wrap_up();
        if (fails == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        `CHK("rd_valid", 1'b1, reg_rd_valid)
        d = reg_rdata;
    endtask

    // collects result channels until the triggered cycle parks the converter
    task automatic wait_done(output int c);
        logic seen;
        seen = 1'b0;
        mask = 5'h00;
        for (int i = 0; i < 40000; i++) begin
            @(posedge clock);
            #1;
            if (result_valid === 1'b1) begin
                seen = 1'b1;
                mask[result_channel] = 1'b1;
                c = i;
            end
            if (seen && (converter_idle === 1'b1 || converter_power_down === 1'b1)) begin
                return;
            end
        end
        fails++;
        $display("[ERR] wait_done exp %h got %h", 1'b1, 1'b0);
        wrap_up();
    endtask

    task automatic trig(input logic [7:0] m, output int c);
        wr_reg(ADDR_ACQ_MODE, {8'h00, m});
        wait_done(c);
    endtask

    task automatic starts_in(input int len, output int s);
        s = 0;
        for (int i = 0; i < len; i++) begin
            @(posedge clock);
            #1;
            if (conv_start === 1'b1) begin
                s++;
            end
        end
    endtask

    initial begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        starts_in(140, n);
        `CHK("start_after_reset", 1'b1, n > 0)
        `CHK("pd_after_reset", 1'b0, converter_power_down)
        foreach (ROWS[k]) begin
            if (ROWS[k].w) begin
                wr_reg(ROWS[k].a, ROWS[k].d);
            end
            rd_reg(ROWS[k].a, rd);
            `CHK("reg_row", ROWS[k].e, rd)
        end
        wr_reg(ADDR_ACQ_MODE, 16'h002a);
        starts_in(300, n);
        `CHK("idle_starts", 0, n)
        `CHK("idle_out", 1'b1, converter_idle)
        wr_reg(ADDR_ACQ_MODE, 16'h004a);
        starts_in(300, n);
        `CHK("pd_starts", 0, n)
        `CHK("pd_out", 1'b1, converter_power_down)
        // each time code runs one sample on the primary shunt; overhead cancels in the difference
        for (int c = 0; c < 8; c++) begin
            wr_reg(ADDR_SHUNT_CFG, 16'(c));
            trig(8'h00, cyc);
            sh = c[2] ? (c[1] ? 5 : 4) : c[1:0];
            if (c == 0) begin
                t0 = cyc;
            end
            `CHK("time_code", (4 << sh) - 4, cyc - t0)
        end
        wr_reg(ADDR_SHUNT_CFG, 16'h0000);
        for (int m = 0; m < 8; m++) begin
            trig(8'(m), cyc);
            `CHK("mode_inputs", MASKS[m], mask)
        end
        @(posedge clock);
        ovf_req <= 1'b1;
        trig(8'h00, cyc);
        rd_reg(ADDR_CONV_STATUS, rd);
        `CHK("status_ovf", 16'h0003, rd)
        `CHK("post_idle", 1'b1, converter_idle)
        `CHK("single_data", 16'h0100, result_data & 16'hfffb)
        starts_in(100, n);
        `CHK("single_shot", 0, n)
        @(posedge clock);
        ovf_req <= 1'b0;
        wr_reg(ADDR_ACQ_MODE, 16'h0010);
        rd_reg(ADDR_CONV_STATUS, rd);
        `CHK("ready_rearm", 1'b0, rd[STAT_RDY_BIT])
        trig(8'h10, cyc);
        rd_reg(ADDR_CONV_STATUS, rd);
        `CHK("status_clear", 16'h0002, rd)
        `CHK("post_pd", 1'b1, converter_power_down)
        wr_reg(ADDR_SHUNT_CFG, 16'h0410);
        trig(8'h00, cyc);
        `CHK("avg_pri", 16'h0102, shunt_result_primary)
        trig(8'h03, cyc);
        `CHK("avg_aux", 16'h2102, shunt_result_aux)
        wr_reg(ADDR_SHUNT_CFG, 16'h0060);
        trig(8'h00, cyc);
        `CHK("avg_4096", 1'b1, cyc >= 4096 * 4)
        `CHK("avg_4096_data", 16'h0102, shunt_result_primary)
        // mid-run reset brings every register back and restarts the default acquisition
        @(posedge clock);
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        starts_in(3, n);
        `CHK("rst_run", 1'b1, n > 0)
        rd_reg(ADDR_ACQ_MODE, rd);
        `CHK("rst_mode", 16'h000a, rd)
        rd_reg(ADDR_SHUNT_CFG, rd);
        `CHK("rst_cfg", 16'h0387, rd)
        rd_reg(ADDR_CONV_STATUS, rd);
        `CHK("rst_status", 16'h0000, rd)
        wr_reg(ADDR_SHUNT_CFG, 16'h0000);
        wr_reg(ADDR_ACQ_MODE, 16'h0008);
        starts_in(60, n);
        `CHK("cont_repeats", 1'b1, n >= 4)
        wrap_up();
    end
endmodule
